// file: hdl/tdmp_mapper.sv
// Port slot mapper top: APB registers, slot gather and scatter, control leads
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module tdmp_mapper (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tdm_fs,
   input wire logic tdm_bit_en,
   input wire logic tdm_rx_bit,
   output logic tdm_tx_bit,
   output logic tdm_tx_oe,
   input wire logic link_up,
   input wire logic port_sd,
   output logic port_rd,
   output logic port_bit_stb,
   input wire logic local_rts,
   input wire logic remote_rts,
   input wire logic remote_rlsd,
   output logic rlsd,
   output logic dsr,
   output logic cts,
   output logic dce_leads_oe,
   output logic rts_out,
   output logic dtr_out,
   output logic dte_leads_oe,
   output logic dest_is_wan,
   output logic [2:0] dest_wan_port,
   output logic [2:0] dest_card_slot,
   output logic [3:0] dest_card_port
);

   typedef struct packed {
      logic [31:0] sh_ctrl;
      logic [31:0] sh_slots;
      logic [31:0] ac_ctrl;
      logic [31:0] ac_slots;
      logic [31:0] rdata;
      logic rerr;
      logic tx_bit;
      logic tx_oe;
      logic rd;
      logic stb;
   } tdmp_state_t;

   tdmp_state_t s_q;
   tdmp_state_t s_d;

   logic [4:0] cur_slot;
   logic [2:0] cur_bit;
   logic actv;
   logic rate64;
   logic e1;
   logic e1_sig;
   logic [31:0] legal;
   logic [31:0] eff_slots;
   logic [5:0] slot_count;
   logic [10:0] port_kbps;
   logic [3:0] port_req;
   logic [2:0] nports;
   logic [3:0] eff_port;
   logic in_slot;
   logic payload;
   logic wr_acc;
   logic rd_setup;
   logic addr_ok;
   logic [31:0] rd_word;
   logic [10:0] slot_kbps;
   logic do_commit;
   logic do_revert;

   // ****************************************
   // Committed configuration fields
   // ****************************************
   assign actv = s_q.ac_ctrl[tdmp_pkg::F_ACTV];
   assign rate64 = s_q.ac_ctrl[tdmp_pkg::F_RATE64];
   assign e1 = s_q.ac_ctrl[tdmp_pkg::F_E1];
   assign e1_sig = s_q.ac_ctrl[tdmp_pkg::F_E1_SIG];
   assign port_req = s_q.ac_ctrl[tdmp_pkg::F_PORT_LO +: 4];
   assign nports = s_q.ac_ctrl[tdmp_pkg::F_NPORTS_LO +: 3];

   // ****************************************
   // Legal slots and effective assignment
   // ****************************************
   always_comb begin
      legal = '0;
      for (int i = 1; i < 32; i++) begin
         if (e1) begin
            legal[i] = (5'(i) <= tdmp_pkg::E1_LAST_SLOT);
            if (e1_sig && (5'(i) == tdmp_pkg::E1_SIG_SLOT)) begin
               legal[i] = 1'b0;
            end
         end else begin
            legal[i] = (5'(i) <= tdmp_pkg::T1_LAST_SLOT);
         end
      end
   end

   // Any subset of one link, one slot up to all of them
   assign eff_slots = s_q.ac_slots & legal;

   always_comb begin
      slot_count = '0;
      for (int i = 0; i < 32; i++) begin
         slot_count = slot_count + {5'h00, eff_slots[i]};
      end
   end

   // Status only; the line rate itself is set by the slots carried
   assign slot_kbps = rate64 ? tdmp_pkg::KBPS_64 : tdmp_pkg::KBPS_56;
   assign port_kbps = 11'(slot_kbps * {5'h00, slot_count});

   // ****************************************
   // Destination routing
   // ****************************************
   always_comb begin
      eff_port = port_req;
      if ((port_req == 4'h0) || (port_req > {1'b0, nports})) begin
         eff_port = tdmp_pkg::DEFAULT_PORT;
      end
   end

   assign dest_is_wan = !s_q.ac_ctrl[tdmp_pkg::F_DEST_USER];
   assign dest_wan_port = s_q.ac_ctrl[tdmp_pkg::F_WAN_LO +: 3];
   assign dest_card_slot = s_q.ac_ctrl[tdmp_pkg::F_CARD_LO +: 3];
   assign dest_card_port = eff_port;

   // ****************************************
   // Bus decode
   // ****************************************
   assign wr_acc = psel && penable && pwrite;
   assign rd_setup = psel && !penable;

   always_comb begin
      case (paddr)
         tdmp_pkg::ADDR_CTRL,
         tdmp_pkg::ADDR_SLOTS,
         tdmp_pkg::ADDR_CMD,
         tdmp_pkg::ADDR_STATUS,
         tdmp_pkg::ADDR_ACT_CTRL,
         tdmp_pkg::ADDR_ACT_SLOTS: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // ****************************************
   // Command decode
   // ****************************************
   assign do_commit = pwdata[tdmp_pkg::C_COMMIT];
   // Commit wins if both bits are written together
   assign do_revert = pwdata[tdmp_pkg::C_REVERT] && !pwdata[tdmp_pkg::C_COMMIT];

   // ****************************************
   // Read data selection
   // ****************************************
   always_comb begin
      // Unmapped offsets read as zero
      rd_word = 32'h0000_0000;
      case (paddr)
         tdmp_pkg::ADDR_CTRL: rd_word = s_q.sh_ctrl;
         tdmp_pkg::ADDR_SLOTS: rd_word = s_q.sh_slots;
         tdmp_pkg::ADDR_STATUS: begin
            rd_word[tdmp_pkg::S_LINK] = link_up;
            rd_word[tdmp_pkg::S_COUNT_LO +: 6] = slot_count;
            rd_word[tdmp_pkg::S_KBPS_LO +: 11] = port_kbps;
         end
         tdmp_pkg::ADDR_ACT_CTRL: rd_word = s_q.ac_ctrl;
         tdmp_pkg::ADDR_ACT_SLOTS: rd_word = eff_slots;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   assign in_slot = eff_slots[cur_slot];
   assign payload = in_slot && (rate64 || (cur_bit != tdmp_pkg::FILL_BIT_POS));

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_d = s_q;
      // Answer and read data are caught in the setup cycle, zero wait states
      if (rd_setup) begin
         s_d.rerr = !addr_ok;
         s_d.rdata = rd_word;
      end

      // ****************************************
      // Register writes and commands
      // ****************************************
      if (wr_acc) begin
         case (paddr)
            tdmp_pkg::ADDR_CTRL: s_d.sh_ctrl = pwdata & tdmp_pkg::CTRL_WMASK;
            tdmp_pkg::ADDR_SLOTS: s_d.sh_slots = pwdata;
            tdmp_pkg::ADDR_CMD: begin
               if (do_commit) begin
                  s_d.ac_ctrl = s_q.sh_ctrl;
                  s_d.ac_slots = s_q.sh_slots;
               end else if (do_revert) begin
                  s_d.sh_ctrl = s_q.ac_ctrl;
                  s_d.sh_slots = s_q.ac_slots;
               end
            end
            default: s_d.sh_ctrl = s_q.sh_ctrl;
         endcase
      end

      // ****************************************
      // TDM bit exchange
      // ****************************************
      // Port strobe is a pulse on the cycle after a payload bit
      s_d.stb = 1'b0;
      if (!actv) begin
         s_d.tx_oe = 1'b0;
      end else if (tdm_bit_en) begin
         s_d.tx_oe = in_slot;
         s_d.tx_bit = tdmp_pkg::FILL_VALUE;
         if (payload) begin
            s_d.tx_bit = port_sd;
            s_d.rd = tdm_rx_bit;
            s_d.stb = 1'b1;
         end
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{sh_ctrl: tdmp_pkg::CTRL_RST, sh_slots: tdmp_pkg::SLOTS_RST,
                  ac_ctrl: tdmp_pkg::CTRL_RST, ac_slots: tdmp_pkg::SLOTS_RST,
                  rdata: 32'h0000_0000, rerr: 1'b0, tx_bit: 1'b0, tx_oe: 1'b0,
                  rd: 1'b0, stb: 1'b0};
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.rdata;
   assign pslverr = s_q.rerr && psel && penable;
   assign pready = 1'b1;
   assign tdm_tx_bit = s_q.tx_bit;
   assign tdm_tx_oe = s_q.tx_oe;
   assign port_rd = s_q.rd;
   assign port_bit_stb = s_q.stb;

   // ****************************************
   // Sub-blocks
   // ****************************************
   tdmp_slot_ctr u_ctr (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .e1(e1),
      .tdm_fs(tdm_fs),
      .tdm_bit_en(tdm_bit_en),
      .cur_slot(cur_slot),
      .cur_bit(cur_bit)
   );

   tdmp_leads u_leads (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .actv(actv),
      .link_up(link_up),
      .role_dte(s_q.ac_ctrl[tdmp_pkg::F_DTE]),
      .cts_opt(s_q.ac_ctrl[tdmp_pkg::F_CTS_LO +: 2]),
      .rlsd_follow(s_q.ac_ctrl[tdmp_pkg::F_RLSD_FOLLOW]),
      .local_rts(local_rts),
      .remote_rts(remote_rts),
      .remote_rlsd(remote_rlsd),
      .rlsd(rlsd),
      .dsr(dsr),
      .cts(cts),
      .dce_leads_oe(dce_leads_oe),
      .rts_out(rts_out),
      .dtr_out(dtr_out),
      .dte_leads_oe(dte_leads_oe)
   );

endmodule : tdmp_mapper
`default_nettype wire

// file: inc/tdmp_pkg.sv
// Package of register map, field layout and constants for the TDM port slot mapper
package tdmp_pkg;

   // ****************************************
   // Register byte addresses
   // ****************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SLOTS = 8'h04;
   localparam logic [7:0] ADDR_CMD = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_ACT_CTRL = 8'h10;
   localparam logic [7:0] ADDR_ACT_SLOTS = 8'h14;

   // ****************************************
   // Control word fields
   // ****************************************
   localparam int unsigned F_ACTV = 0;
   localparam int unsigned F_RATE64 = 1;
   localparam int unsigned F_DTE = 2;
   localparam int unsigned F_CTS_LO = 3;
   localparam int unsigned F_RLSD_FOLLOW = 5;
   localparam int unsigned F_DEST_USER = 6;
   localparam int unsigned F_E1 = 7;
   localparam int unsigned F_E1_SIG = 8;
   localparam int unsigned F_WAN_LO = 10;
   localparam int unsigned F_CARD_LO = 13;
   localparam int unsigned F_PORT_LO = 16;
   localparam int unsigned F_NPORTS_LO = 20;
   localparam logic [31:0] CTRL_WMASK = 32'h007F_FDFF;

   // Command word bits
   localparam int unsigned C_COMMIT = 0;
   localparam int unsigned C_REVERT = 1;

   // Status word fields
   localparam int unsigned S_LINK = 0;
   localparam int unsigned S_COUNT_LO = 8;
   localparam int unsigned S_KBPS_LO = 16;

   // ****************************************
   // Reset values: standby, 56k, DCE, no slots
   // ****************************************
   localparam logic [31:0] CTRL_RST = 32'h0040_0000;
   localparam logic [31:0] SLOTS_RST = 32'h0000_0000;

   // ****************************************
   // Framing and rate constants
   // ****************************************
   localparam logic [4:0] T1_LAST_SLOT = 5'h18;
   localparam logic [4:0] E1_LAST_SLOT = 5'h1F;
   localparam logic [4:0] E1_SIG_SLOT = 5'h10;
   localparam logic [4:0] T1_FIRST_SLOT = 5'h01;
   localparam logic [4:0] E1_FIRST_SLOT = 5'h00;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] FILL_BIT_POS = 3'h7;
   localparam logic FILL_VALUE = 1'b1;
   localparam logic [10:0] KBPS_56 = 11'h038;
   localparam logic [10:0] KBPS_64 = 11'h040;
   localparam logic [3:0] DEFAULT_PORT = 4'h1;

   typedef enum logic [1:0] {
      TDMP_CTS_PERM,
      TDMP_CTS_RLOCAL,
      TDMP_CTS_IGNOR,
      TDMP_CTS_LOCAL
   } tdmp_cts_t;

endpackage : tdmp_pkg

// file: hdl/tdmp_slot_ctr.sv
// Frame position counter: slot number and bit index of the current TDM bit
`timescale 1ns/1ps
`default_nettype none
module tdmp_slot_ctr (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic e1,
   input wire logic tdm_fs,
   input wire logic tdm_bit_en,
   output logic [4:0] cur_slot,
   output logic [2:0] cur_bit
);

   typedef struct packed {
      logic [4:0] slot;
      logic [2:0] bitn;
   } tdmp_ctr_t;

   tdmp_ctr_t s_q;
   tdmp_ctr_t s_d;

   // ****************************************
   // Position of the bit on the bus now
   // ****************************************
   always_comb begin
      cur_slot = s_q.slot;
      cur_bit = s_q.bitn;
      if (tdm_fs) begin
         cur_slot = e1 ? tdmp_pkg::E1_FIRST_SLOT : tdmp_pkg::T1_FIRST_SLOT;
         cur_bit = 3'h0;
      end
      s_d = s_q;
      if (tdm_bit_en) begin
         s_d.bitn = cur_bit + 3'h1;
         // Frame sync realigns the stored slot as well as the bit
         s_d.slot = cur_slot;
         if (cur_bit == tdmp_pkg::BIT_LAST) begin
            // Wraps freely; the next frame sync realigns it
            s_d.slot = cur_slot + 5'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

endmodule : tdmp_slot_ctr
`default_nettype wire

// file: hdl/tdmp_leads.sv
// Modem control lead driver for one port, DCE or DTE role
`timescale 1ns/1ps
`default_nettype none
module tdmp_leads (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic actv,
   input wire logic link_up,
   input wire logic role_dte,
   input wire logic [1:0] cts_opt,
   input wire logic rlsd_follow,
   input wire logic local_rts,
   input wire logic remote_rts,
   input wire logic remote_rlsd,
   output logic rlsd,
   output logic dsr,
   output logic cts,
   output logic dce_leads_oe,
   output logic rts_out,
   output logic dtr_out,
   output logic dte_leads_oe
);

   typedef struct packed {
      logic rlsd;
      logic dsr;
      logic cts;
      logic dce_oe;
      logic rts;
      logic dtr;
      logic dte_oe;
   } tdmp_lead_t;

   tdmp_lead_t s_q;
   tdmp_lead_t s_d;

   // ****************************************
   // Lead levels from state and link
   // ****************************************
   always_comb begin
      s_d = s_q;
      s_d.rlsd = actv && link_up && (rlsd_follow ? remote_rts : 1'b1);
      s_d.dsr = actv;
      if (!actv) begin
         s_d.cts = 1'b1;
      end else begin
         case (tdmp_pkg::tdmp_cts_t'(cts_opt))
            tdmp_pkg::TDMP_CTS_PERM: s_d.cts = 1'b1;
            tdmp_pkg::TDMP_CTS_RLOCAL: s_d.cts = local_rts && remote_rlsd;
            tdmp_pkg::TDMP_CTS_IGNOR: s_d.cts = 1'b0;
            tdmp_pkg::TDMP_CTS_LOCAL: s_d.cts = local_rts;
            default: s_d.cts = 1'b1;
         endcase
      end
      // A DTE drives its own request leads and leaves the DCE circuits alone
      s_d.dce_oe = !role_dte;
      s_d.dte_oe = role_dte;
      s_d.rts = role_dte && actv;
      s_d.dtr = role_dte && actv;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{rlsd: 1'b0, dsr: 1'b0, cts: 1'b1, dce_oe: 1'b1,
                  rts: 1'b0, dtr: 1'b0, dte_oe: 1'b0};
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign rlsd = s_q.rlsd;
   assign dsr = s_q.dsr;
   assign cts = s_q.cts;
   assign dce_leads_oe = s_q.dce_oe;
   assign rts_out = s_q.rts;
   assign dtr_out = s_q.dtr;
   assign dte_leads_oe = s_q.dte_oe;

endmodule : tdmp_leads
`default_nettype wire

// file: sim/tdmp_mapper_chk.sv
// Checker of lead and slot timing at the mapper top ports
`timescale 1ns/1ps
`default_nettype none
module tdmp_mapper_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tdm_bit_en,
   input wire logic tdm_tx_oe,
   input wire logic port_bit_stb,
   input wire logic link_up,
   input wire logic rlsd,
   input wire logic dsr,
   input wire logic cts,
   input wire logic dce_leads_oe,
   input wire logic dte_leads_oe,
   input wire logic rts_out,
   input wire logic dtr_out,
   input wire logic [3:0] dest_card_port
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ****
   // Properties
   // ****
   // Dsr mirrors the committed state with the same lag as the slot outputs
   a_stdby_quiet: assert property (!dsr |-> !port_bit_stb && !tdm_tx_oe)
      else $error("standby port touches a slot");
   a_oe_steady: assert property (!$past(tdm_bit_en) && $past(dsr) && dsr |-> $stable(tdm_tx_oe))
      else $error("slot drive moved between bits");
   a_stb_cause: assert property (port_bit_stb |-> $past(tdm_bit_en))
      else $error("strobe without a bit time");
   a_rlsd_cause: assert property (rlsd |-> dsr && $past(link_up))
      else $error("rlsd high while down or standby");
   a_cts_stdby: assert property (!dsr |-> cts)
      else $error("cts low in standby");
   a_role_oe: assert property (dce_leads_oe != dte_leads_oe)
      else $error("both or no lead sets enabled");
   a_dte_leads: assert property (dte_leads_oe |-> rts_out == dsr && dtr_out == dsr)
      else $error("dte leads do not follow state");
   a_port_valid: assert property (dest_card_port != 4'h0)
      else $error("destination port zero");
   c_stb: cover property (port_bit_stb);
   c_rlsd: cover property (rlsd);
   c_dte: cover property (dte_leads_oe);
endmodule : tdmp_mapper_chk
bind tdmp_mapper tdmp_mapper_chk u_chk (.pclk(pclk), .presetn(presetn),
   .tdm_bit_en(tdm_bit_en), .tdm_tx_oe(tdm_tx_oe), .port_bit_stb(port_bit_stb),
   .link_up(link_up), .rlsd(rlsd), .dsr(dsr), .cts(cts), .dce_leads_oe(dce_leads_oe),
   .dte_leads_oe(dte_leads_oe), .rts_out(rts_out), .dtr_out(dtr_out),
   .dest_card_port(dest_card_port));
`default_nettype wire

// file: sim/tdmp_far.sv
// Far side model: TDM link bit timing and terminal send data
`timescale 1ns/1ps
`default_nettype none
module tdmp_far (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic e1,
   input wire logic slow,
   input wire logic sd_one,
   output logic tdm_fs,
   output logic tdm_bit_en,
   output logic tdm_rx_bit,
   output logic port_sd
);
   logic [7:0] pos_q;
   logic [1:0] gap_q;
   // Terminal holds its bit until taken, so a level is enough
   assign port_sd = sd_one;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_q <= 8'h00;
         gap_q <= 2'h0;
         tdm_bit_en <= 1'b0;
         tdm_fs <= 1'b0;
         tdm_rx_bit <= 1'b0;
      end else begin
         tdm_bit_en <= (gap_q == 2'h0);
         tdm_fs <= (gap_q == 2'h0) && (pos_q == 8'h00);
         tdm_rx_bit <= pos_q[0] ^ pos_q[3];
         gap_q <= (gap_q == (slow ? 2'h2 : 2'h1)) ? 2'h0 : gap_q + 2'h1;
         if (gap_q == 2'h0) begin
            pos_q <= (!e1 && pos_q == 8'hBF) ? 8'h00 : pos_q + 8'h01;
         end
      end
   end
endmodule : tdmp_far
`default_nettype wire

// file: sim/tdmp_mapper_test.sv
// Self-checking bench for the port slot mapper
`timescale 1ns/1ps
`default_nettype none
module tdmp_mapper_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic link_up = 1'b0;
   logic local_rts = 1'b0;
   logic remote_rts = 1'b0;
   logic remote_rlsd = 1'b0;
   logic e1 = 1'b0;
   logic slow = 1'b0;
   logic sd_one = 1'b0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rerr, tdm_fs, tdm_bit_en, tdm_rx_bit, tdm_tx_bit, tdm_tx_oe, en_d;
   logic port_sd, port_rd, port_bit_stb, rlsd, dsr, cts, dce_leads_oe, rts_out, dtr_out;
   logic dte_leads_oe, dest_is_wan;
   logic [2:0] dest_wan_port, dest_card_slot;
   logic [3:0] dest_card_port;
   int fails = 0;
   int n_checks = 0;
   int n_stb, n_oe, n_one, n_rd;
   always #2.5 pclk = ~pclk;
   tdmp_mapper dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .tdm_fs, .tdm_bit_en, .tdm_rx_bit, .tdm_tx_bit, .tdm_tx_oe,
      .link_up, .port_sd, .port_rd, .port_bit_stb, .local_rts, .remote_rts, .remote_rlsd,
      .rlsd, .dsr, .cts, .dce_leads_oe, .rts_out, .dtr_out, .dte_leads_oe, .dest_is_wan,
      .dest_wan_port, .dest_card_slot, .dest_card_port);
   tdmp_far far (.pclk, .presetn, .e1, .slow, .sd_one, .tdm_fs, .tdm_bit_en, .tdm_rx_bit,
      .port_sd);
   // ****
   // Monitors and shared tasks
   // ****
   // Outputs lag the bit time by one cycle; a whole-frame window hides that shift
   always @(posedge pclk) begin
      en_d <= tdm_bit_en;
      n_oe += int'(en_d && tdm_tx_oe);
      n_one += int'(en_d && tdm_tx_oe && tdm_tx_bit);
      n_stb += int'(port_bit_stb);
      n_rd += int'(port_bit_stb && port_rd);
   end
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(what, e, rdat);
   endtask : rdc
   task automatic setc(input logic [31:0] c);
      apb(1'b1, tdmp_pkg::ADDR_CTRL, c);
      apb(1'b1, tdmp_pkg::ADDR_CMD, 32'h0000_0001);
      repeat (2) @(posedge pclk);
   endtask : setc
   task automatic frame(input int s, input int o, input int n, input int r);
      int win;
      win = (e1 ? 256 : 192) * (slow ? 3 : 2);
      repeat (win) @(posedge pclk);
      #1;
      n_stb = 0;
      n_oe = 0;
      n_one = 0;
      n_rd = 0;
      repeat (win) @(posedge pclk);
      #1;
      chk("strobes", s, n_stb);
      chk("driven bits", o, n_oe);
      chk("one bits", n, n_one);
      chk("received ones", r, n_rd);
   endtask : frame
   // ****
   // Scenarios
   // ****
   task automatic t_reset();
      chk("leads", 32'h0000_0009, {28'h0, cts, dsr, rlsd, dce_leads_oe});
      chk("dest", 32'h0000_0401, {21'h0, dest_is_wan, dest_wan_port, dest_card_slot,
         dest_card_port});
      rdc("ctrl", tdmp_pkg::ADDR_CTRL, tdmp_pkg::CTRL_RST);
      rdc("slots", tdmp_pkg::ADDR_SLOTS, 32'h0000_0000);
      apb(1'b0, 8'hFC, 32'h0000_0000);
      chk("unmapped err", 32'h0000_0001, {31'h0, rerr});
      $display("test reset done");
   endtask : t_reset
   task automatic t_edit();
      apb(1'b1, tdmp_pkg::ADDR_CTRL, 32'h0040_0001);
      rdc("act ctrl", tdmp_pkg::ADDR_ACT_CTRL, tdmp_pkg::CTRL_RST);
      apb(1'b1, tdmp_pkg::ADDR_CMD, 32'h0000_0002);
      rdc("ctrl", tdmp_pkg::ADDR_CTRL, tdmp_pkg::CTRL_RST);
      chk("dsr", 32'h0000_0000, {31'h0, dsr});
      $display("test edit done");
   endtask : t_edit
   task automatic t_leads();
      logic [31:0] ex;
      link_up <= 1'b1;
      setc(32'h0040_0001);
      chk("rlsd dsr", 32'h0000_0003, {30'h0, rlsd, dsr});
      link_up <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("rlsd dsr", 32'h0000_0001, {30'h0, rlsd, dsr});
      link_up <= 1'b1;
      setc(32'h0040_0021);
      chk("rlsd dsr", 32'h0000_0001, {30'h0, rlsd, dsr});
      remote_rts <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("rlsd dsr", 32'h0000_0003, {30'h0, rlsd, dsr});
      for (int k = 0; k < 4; k++) begin
         local_rts <= k[0];
         remote_rlsd <= k[1];
         for (int o = 0; o < 4; o++) begin
            setc(32'h0040_0001 | (o << 3));
            ex = (o == 0) ? 1 : (o == 1) ? (k == 3) : (o == 3) ? k[0] : 0;
            chk("cts", ex, {31'h0, cts});
         end
      end
      setc(32'h0040_0005);
      chk("dte leads", 32'h0000_0007, {28'h0, dce_leads_oe, dte_leads_oe, rts_out,
         dtr_out});
      $display("test leads done");
   endtask : t_leads
   task automatic t_slots();
      apb(1'b1, tdmp_pkg::ADDR_SLOTS, 32'h0301_081B);
      setc(32'h0040_0001);
      rdc("act slots", tdmp_pkg::ADDR_ACT_SLOTS, 32'h0101_081A);
      rdc("status", tdmp_pkg::ADDR_STATUS, 32'h0150_0601);
      frame(42, 48, 6, 21);
      sd_one <= 1'b1;
      slow <= 1'b1;
      setc(32'h0040_0003);
      rdc("status", tdmp_pkg::ADDR_STATUS, 32'h0180_0601);
      frame(48, 48, 48, 24);
      e1 <= 1'b1;
      apb(1'b1, tdmp_pkg::ADDR_SLOTS, 32'h8001_0005);
      setc(32'h0040_0183);
      rdc("act slots", tdmp_pkg::ADDR_ACT_SLOTS, 32'h8000_0004);
      frame(16, 16, 16, 8);
      setc(32'h0040_0083);
      rdc("act slots", tdmp_pkg::ADDR_ACT_SLOTS, 32'h8001_0004);
      setc(32'h0040_0082);
      frame(0, 0, 0, 0);
      $display("test slots done");
   endtask : t_slots
   task automatic t_dest();
      setc(32'h0049_A040);
      chk("dest", 32'h0000_0051, {21'h0, dest_is_wan, dest_wan_port, dest_card_slot,
         dest_card_port});
      setc(32'h0043_A040);
      chk("dest", 32'h0000_0053, {21'h0, dest_is_wan, dest_wan_port, dest_card_slot,
         dest_card_port});
      setc(32'h0040_1800);
      chk("dest", 32'h0000_0701, {21'h0, dest_is_wan, dest_wan_port, dest_card_slot,
         dest_card_port});
      $display("test dest done");
   endtask : t_dest
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_edit();
      t_leads();
      t_slots();
      t_dest();
      print_verdict();
   end
   initial begin
      repeat (40000) @(posedge pclk);
      fails++;
      print_verdict();
   end
endmodule : tdmp_mapper_test
`default_nettype wire
